// ==== src/tsc_pkg.sv ====
package tsc_pkg;
    // Datapath widths
    localparam int CNT_W = 16;
    localparam int NUM_CH = 4;
    localparam int CH_CFG_W = 5;
    localparam int ADDR_W = 8;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL1 = 8'h00;
    localparam logic [7:0] OFF_CTRL2 = 8'h04;
    localparam logic [7:0] OFF_SMCR = 8'h08;
    localparam logic [7:0] OFF_EGR = 8'h0c;
    localparam logic [7:0] OFF_STAT = 8'h10;
    localparam logic [7:0] OFF_CHCFG = 8'h14;
    localparam logic [7:0] OFF_CHACT = 8'h18;
    localparam logic [7:0] OFF_CNT = 8'h1c;
    localparam logic [7:0] OFF_RELOAD = 8'h20;
    localparam logic [7:0] OFF_CMP1 = 8'h24;
    localparam logic [7:0] OFF_CMP4 = 8'h30;

    // Field positions
    localparam int CTRL1_CEN = 0;
    localparam int CTRL1_CHPRE = 1;
    localparam int CTRL2_MMS_LSB = 0;
    localparam int CTRL2_COMMUTATION_SOURCE_SELECT = 4;
    localparam int SMCR_SMS_LSB = 0;
    localparam int SMCR_TS_LSB = 4;
    localparam int EGR_UG = 0;
    localparam int EGR_COMMUTATION_SOFTWARE_TRIGGER = 1;
    localparam int STAT_MATCH = 0;
    localparam int STAT_COM = 1;
    localparam int CH_EN = 3;
    localparam int CH_NEN = 4;

    // Reset values
    localparam logic [CNT_W-1:0] RELOAD_RST = 16'hffff;
    localparam logic [CNT_W-1:0] CMP_RST = 16'h0000;
    localparam logic [NUM_CH*CH_CFG_W-1:0] CHCFG_RST = 20'h00000;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Master mode selections
    typedef enum logic [2:0] {
        MMS_RESET = 3'b000,
        MMS_ENABLE = 3'b001,
        MMS_UPDATE = 3'b010,
        MMS_CMP_PULSE = 3'b011,
        MMS_REF1 = 3'b100,
        MMS_REF2 = 3'b101,
        MMS_REF3 = 3'b110,
        MMS_REF4 = 3'b111
    } tsc_mms_t;

    // Slave mode selections
    typedef enum logic [1:0] {
        SMS_OFF = 2'b00,
        SMS_RESET = 2'b01,
        SMS_INCR = 2'b10,
        SMS_UPDATE = 2'b11
    } tsc_sms_t;

    // Channel output modes
    localparam logic [2:0] OCM_LOW = 3'b000;
    localparam logic [2:0] OCM_HIGH = 3'b001;
    localparam logic [2:0] OCM_PWM1 = 3'b010;
    localparam logic [2:0] OCM_PWM2 = 3'b011;

    // AXI4-Lite master-to-slave signals
    typedef struct packed {
        logic awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [ADDR_W-1:0] araddr;
        logic rready;
    } tsc_axi_req_t;

    // AXI4-Lite slave-to-master signals
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } tsc_axi_rsp_t;

    // Whole state of the timer
    typedef struct packed {
        logic awHave;
        logic [ADDR_W-1:0] awAddr;
        logic wHave;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic bValid;
        logic [1:0] bResp;
        logic rValid;
        logic [31:0] rData;
        logic [1:0] rResp;
        logic cen;
        logic chPre;
        tsc_mms_t master_mode_select;
        logic commutation_source_select;
        tsc_sms_t slave_mode_select;
        logic [1:0] ts;
        logic ugPend;
        logic comPend;
        logic [NUM_CH*CH_CFG_W-1:0] chPreload;
        logic [NUM_CH*CH_CFG_W-1:0] chActive;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] reloadPre;
        logic [CNT_W-1:0] reloadAct;
        logic [NUM_CH-1:0][CNT_W-1:0] cmp;
        logic matchFlag;
        logic comFlag;
        logic trgPrev;
        logic trgOut;
        logic [NUM_CH-1:0] chOut;
        logic [NUM_CH-1:0] chOutN;
    } tsc_state_t;
endpackage

// ==== src/tsc_timer_sync.sv ====
module tsc_timer_sync (
    input wire logic clock,
    input wire logic rst,
    input wire tsc_pkg::tsc_axi_req_t axiReq,
    output tsc_pkg::tsc_axi_rsp_t axiRsp,
    input wire logic [tsc_pkg::NUM_CH-1:0] syncIn,
    output logic triggerOut,
    output logic [tsc_pkg::NUM_CH-1:0] chOut,
    output logic [tsc_pkg::NUM_CH-1:0] chOutN
);
    import tsc_pkg::*;

    tsc_state_t state_r;
    tsc_state_t state_nxt;

    // Byte strobes widened to a bit mask
    function automatic logic [31:0] strbMask(input logic [3:0] strb);
        logic [31:0] m;
        m = 32'h00000000;
        for (int i = 0; i < 4; i++) begin
            m[8*i +: 8] = {8{strb[i]}};
        end
        return m;
    endfunction

    // Channel reference level from mode, counter and compare value
    function automatic logic ocRef(input logic [2:0] mode, input logic [CNT_W-1:0] cnt,
                                   input logic [CNT_W-1:0] cmp);
        logic r;
        r = 1'b0;
        case (mode)
            OCM_HIGH: r = 1'b1;
            OCM_PWM1: r = (cnt < cmp);
            OCM_PWM2: r = (cnt >= cmp);
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    // Register readback; ok low on unmapped offsets
    function automatic logic [32:0] regRead(input tsc_state_t s, input logic [ADDR_W-1:0] a);
        logic [32:0] r;
        r = {1'b1, 32'h00000000};
        case ({a[ADDR_W-1:2], 2'b00})
            OFF_CTRL1: begin
                r[CTRL1_CEN] = s.cen;
                r[CTRL1_CHPRE] = s.chPre;
            end
            OFF_CTRL2: begin
                r[CTRL2_MMS_LSB +: 3] = s.master_mode_select;
                r[CTRL2_COMMUTATION_SOURCE_SELECT] = s.commutation_source_select;
            end
            OFF_SMCR: begin
                r[SMCR_SMS_LSB +: 2] = s.slave_mode_select;
                r[SMCR_TS_LSB +: 2] = s.ts;
            end
            OFF_EGR: begin
                r[EGR_UG] = s.ugPend;
                r[EGR_COMMUTATION_SOFTWARE_TRIGGER] = s.comPend;
            end
            OFF_STAT: begin
                r[STAT_MATCH] = s.matchFlag;
                r[STAT_COM] = s.comFlag;
            end
            OFF_CHCFG: r[NUM_CH*CH_CFG_W-1:0] = s.chPreload;
            OFF_CHACT: r[NUM_CH*CH_CFG_W-1:0] = s.chActive;
            OFF_CNT: r[CNT_W-1:0] = s.cnt;
            OFF_RELOAD: r[CNT_W-1:0] = s.reloadPre;
            default: begin
                if ({a[ADDR_W-1:2], 2'b00} >= OFF_CMP1 && {a[ADDR_W-1:2], 2'b00} <= OFF_CMP4) begin
                    r[CNT_W-1:0] = s.cmp[2'(a[ADDR_W-1:2] - OFF_CMP1[ADDR_W-1:2])];
                end else begin
                    r[32] = 1'b0;
                end
            end
        endcase
        return r;
    endfunction

    // Bus handshakes and registered answers
    always_comb begin
        axiRsp.awready = !state_r.awHave && !state_r.bValid;
        axiRsp.wready = !state_r.wHave && !state_r.bValid;
        axiRsp.bvalid = state_r.bValid;
        axiRsp.bresp = state_r.bResp;
        axiRsp.arready = !state_r.rValid;
        axiRsp.rvalid = state_r.rValid;
        axiRsp.rdata = state_r.rData;
        axiRsp.rresp = state_r.rResp;
    end

    // Outputs straight from state flip-flops
    assign triggerOut = state_r.trgOut;
    assign chOut = state_r.chOut;
    assign chOutN = state_r.chOutN;

    // Next-state logic
    always_comb begin
        logic [32:0] rd;
        logic [31:0] m;
        logic [31:0] wv;
        logic doWrite;
        logic selIn;
        logic trgEdge;
        logic cntStep;
        logic ovf;
        logic upd;
        logic matchEv;
        logic com;
        logic [NUM_CH-1:0] refLvl;
        logic [CH_CFG_W-1:0] cfg;
        logic [ADDR_W-1:0] wa;
        state_nxt = state_r;
        rd = 33'h000000000;
        m = 32'h00000000;
        wv = 32'h00000000;
        wa = state_r.awAddr;
        doWrite = state_r.awHave && state_r.wHave && !state_r.bValid;
        selIn = 1'b0;
        trgEdge = 1'b0;
        cntStep = 1'b0;
        ovf = 1'b0;
        upd = 1'b0;
        matchEv = 1'b0;
        com = 1'b0;
        refLvl = '0;
        cfg = '0;

        // Slave side: one selected input, edge against last cycle
        selIn = syncIn[state_r.ts];
        trgEdge = selIn && !state_r.trgPrev;
        state_nxt.trgPrev = selIn;

        // Counter step, overflow and update sources
        cntStep = (state_r.slave_mode_select == SMS_INCR) ? trgEdge : 1'b1;
        ovf = state_r.cen && cntStep && (state_r.cnt == state_r.reloadAct);
        upd = state_r.ugPend || ovf || (trgEdge && state_r.slave_mode_select == SMS_UPDATE);
        matchEv = state_r.cen && cntStep && (state_r.cnt == state_r.cmp[0]);
        com = state_r.comPend || (state_r.commutation_source_select && trgEdge);

        // Counter clears on update or slave reset edge, else steps when enabled
        if (upd || (trgEdge && state_r.slave_mode_select == SMS_RESET)) begin
            state_nxt.cnt = '0;
        end else if (state_r.cen && cntStep) begin
            state_nxt.cnt = state_r.cnt + 16'h0001;
        end
        if (upd) begin
            state_nxt.reloadAct = state_r.reloadPre;
        end
        state_nxt.ugPend = 1'b0;
        state_nxt.comPend = 1'b0;
        if (com) begin
            state_nxt.chActive = state_r.chPreload;
        end

        // Write address and data captured in either order
        if (axiReq.awvalid && axiRsp.awready) begin
            state_nxt.awHave = 1'b1;
            state_nxt.awAddr = axiReq.awaddr;
        end
        if (axiReq.wvalid && axiRsp.wready) begin
            state_nxt.wHave = 1'b1;
            state_nxt.wData = axiReq.wdata;
            state_nxt.wStrb = axiReq.wstrb;
        end
        if (state_r.bValid && axiReq.bready) begin
            state_nxt.bValid = 1'b0;
        end

        // Register write once both halves are held
        if (doWrite) begin
            rd = regRead(state_r, wa);
            m = strbMask(state_r.wStrb);
            wv = (rd[31:0] & ~m) | (state_r.wData & m);
            state_nxt.awHave = 1'b0;
            state_nxt.wHave = 1'b0;
            state_nxt.bValid = 1'b1;
            state_nxt.bResp = rd[32] ? RESP_OKAY : RESP_SLVERR;
            case ({wa[ADDR_W-1:2], 2'b00})
                OFF_CTRL1: begin
                    state_nxt.cen = wv[CTRL1_CEN];
                    state_nxt.chPre = wv[CTRL1_CHPRE];
                end
                OFF_CTRL2: begin
                    state_nxt.master_mode_select = tsc_mms_t'(wv[CTRL2_MMS_LSB +: 3]);
                    state_nxt.commutation_source_select = wv[CTRL2_COMMUTATION_SOURCE_SELECT];
                end
                OFF_SMCR: begin
                    state_nxt.slave_mode_select = tsc_sms_t'(wv[SMCR_SMS_LSB +: 2]);
                    state_nxt.ts = wv[SMCR_TS_LSB +: 2];
                end
                OFF_EGR: begin
                    if (m[EGR_UG] && state_r.wData[EGR_UG]) begin
                        state_nxt.ugPend = 1'b1;
                    end
                    if (m[EGR_COMMUTATION_SOFTWARE_TRIGGER] && state_r.wData[EGR_COMMUTATION_SOFTWARE_TRIGGER]) begin
                        state_nxt.comPend = 1'b1;
                    end
                end
                OFF_STAT: begin
                    state_nxt.matchFlag = state_r.matchFlag && !(m[STAT_MATCH] && state_r.wData[STAT_MATCH]);
                    state_nxt.comFlag = state_r.comFlag && !(m[STAT_COM] && state_r.wData[STAT_COM]);
                end
                OFF_CHCFG: begin
                    state_nxt.chPreload = wv[NUM_CH*CH_CFG_W-1:0];
                    if (!state_r.chPre) begin
                        state_nxt.chActive = wv[NUM_CH*CH_CFG_W-1:0];
                    end
                end
                OFF_CNT: state_nxt.cnt = wv[CNT_W-1:0];
                OFF_RELOAD: state_nxt.reloadPre = wv[CNT_W-1:0];
                default: begin
                    if (rd[32] && {wa[ADDR_W-1:2], 2'b00} >= OFF_CMP1) begin
                        state_nxt.cmp[2'(wa[ADDR_W-1:2] - OFF_CMP1[ADDR_W-1:2])] = wv[CNT_W-1:0];
                    end
                end
            endcase
        end

        // Read channel
        if (axiReq.arvalid && axiRsp.arready) begin
            rd = regRead(state_r, axiReq.araddr);
            state_nxt.rValid = 1'b1;
            state_nxt.rData = rd[31:0];
            state_nxt.rResp = rd[32] ? RESP_OKAY : RESP_SLVERR;
        end else if (state_r.rValid && axiReq.rready) begin
            state_nxt.rValid = 1'b0;
        end

        // Sticky flags; a new event wins over a clear
        if (matchEv) begin
            state_nxt.matchFlag = 1'b1;
        end
        if (com) begin
            state_nxt.comFlag = 1'b1;
        end

        // Channel references and gated outputs from active copies
        for (int i = 0; i < NUM_CH; i++) begin
            cfg = state_r.chActive[i*CH_CFG_W +: CH_CFG_W];
            refLvl[i] = ocRef(cfg[2:0], state_r.cnt, state_r.cmp[i]);
            state_nxt.chOut[i] = cfg[CH_EN] && refLvl[i];
            state_nxt.chOutN[i] = cfg[CH_NEN] && !refLvl[i];
        end

        // Trigger output source per master mode
        case (state_r.master_mode_select)
            MMS_RESET: state_nxt.trgOut = state_r.ugPend;
            MMS_ENABLE: state_nxt.trgOut = state_r.cen;
            MMS_UPDATE: state_nxt.trgOut = upd;
            MMS_CMP_PULSE: state_nxt.trgOut = matchEv;
            MMS_REF1: state_nxt.trgOut = refLvl[0];
            MMS_REF2: state_nxt.trgOut = refLvl[1];
            MMS_REF3: state_nxt.trgOut = refLvl[2];
            MMS_REF4: state_nxt.trgOut = refLvl[3];
            default: state_nxt.trgOut = 1'b0;
        endcase
    end

    // State register with synchronous reset
    always_ff @(posedge clock) begin
        if (rst) begin
            state_r <= '0;
            state_r.master_mode_select <= MMS_RESET;
            state_r.slave_mode_select <= SMS_OFF;
            state_r.reloadPre <= RELOAD_RST;
            state_r.reloadAct <= RELOAD_RST;
            state_r.cmp <= {NUM_CH{CMP_RST}};
            state_r.chPreload <= CHCFG_RST;
            state_r.chActive <= CHCFG_RST;
        end else begin
            state_r <= state_nxt;
        end
    end
endmodule

// ==== test/tsc_peer_model.sv ====
module tsc_peer_model #(
    parameter int HOLD = 3
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [3:0] fire,
    output logic [3:0] syncIn
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] line_r;
    int left_r;

    // Each peer timer raises its trigger line for HOLD cycles when told to fire
    always_ff @(posedge clock) begin
        if (rst) begin
            line_r <= 4'h0;
            left_r <= 0;
        end else if (fire != 4'h0) begin
            line_r <= fire;
            left_r <= HOLD;
        end else if (left_r > 0) begin
            left_r <= left_r - 1;
        end
    end

    // A line falls back low once its hold time has run out
    assign syncIn = (left_r > 0) ? line_r : 4'h0;
endmodule

// ==== test/tsc_timer_sync_chk.sv ====
module tsc_timer_sync_chk (
    input wire logic clock,
    input wire logic rst,
    input wire tsc_pkg::tsc_axi_req_t axiReq,
    input wire tsc_pkg::tsc_axi_rsp_t axiRsp,
    input wire logic [tsc_pkg::NUM_CH-1:0] syncIn,
    input wire logic triggerOut,
    input wire logic [tsc_pkg::NUM_CH-1:0] chOut,
    input wire logic [tsc_pkg::NUM_CH-1:0] chOutN
);
    timeunit 1ns;
    timeprecision 1ps;
    import tsc_pkg::*;
    logic [2:0] mode_r;
    logic cen_r;
    logic wTake;

    // A write whose address and data are taken at the same edge
    assign wTake = axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready;

    // Shadow of master mode and counter enable, followed from bus writes
    always_ff @(posedge clock) begin
        if (rst) begin
            mode_r <= 3'h0;
            cen_r <= 1'b0;
        end else if (wTake && axiReq.awaddr == OFF_CTRL2) begin
            mode_r <= axiReq.wdata[2:0];
        end else if (wTake && axiReq.awaddr == OFF_CTRL1) begin
            cen_r <= axiReq.wdata[0];
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    a_bresp_hold: assert property (axiRsp.bvalid && !axiReq.bready |=> axiRsp.bvalid && $stable(axiRsp.bresp))
        else $error("write response dropped early");
    a_rdata_hold: assert property (axiRsp.rvalid && !axiReq.rready |=> axiRsp.rvalid && $stable(axiRsp.rdata))
        else $error("read data dropped early");
    a_write_answer: assert property (wTake |-> ##2 axiRsp.bvalid)
        else $error("write response late");
    a_read_answer: assert property (axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid)
        else $error("read data late");
    a_busy_refuse: assert property (axiRsp.bvalid |-> !axiRsp.awready && !axiRsp.wready)
        else $error("write taken while response pending");
    a_event_pulse: assert property ((mode_r inside {3'h0, 3'h2, 3'h3}) && mode_r == $past(mode_r, 3)
        && triggerOut |=> !triggerOut) else $error("event trigger longer than one cycle");
    a_reset_pulse: assert property (mode_r == 3'h0 && wTake && axiReq.awaddr == OFF_EGR
        && axiReq.wdata[EGR_UG] |-> ##[1:3] triggerOut) else $error("no trigger after update request");
    a_enable_level: assert property (mode_r == 3'h1 && mode_r == $past(mode_r, 3)
        && cen_r == $past(cen_r, 3) |-> triggerOut == cen_r) else $error("trigger not following enable");
    a_ch_exclusive: assert property ((chOut & chOutN) == 4'h0)
        else $error("both channel outputs active");
endmodule

bind tsc_timer_sync tsc_timer_sync_chk chk (.clock(clock), .rst(rst), .axiReq(axiReq), .axiRsp(axiRsp),
    .syncIn(syncIn), .triggerOut(triggerOut), .chOut(chOut), .chOutN(chOutN));

// ==== test/test_timer_sync_commutation.sv ====
module test_timer_sync_commutation;
    timeunit 1ns;
    timeprecision 1ps;
    import tsc_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    tsc_axi_req_t req = '0;
    tsc_axi_rsp_t rsp;
    logic [3:0] syncIn, chOut, chOutN;
    logic [3:0] fire = 4'h0;
    logic triggerOut;
    int errors = 0, checks_done = 0, cycles = 0, trigHigh = 0, t0;

    tsc_timer_sync uut (.clock(clock), .rst(rst), .axiReq(req), .axiRsp(rsp), .syncIn(syncIn),
        .triggerOut(triggerOut), .chOut(chOut), .chOutN(chOutN));
    tsc_peer_model #(.HOLD(3)) peer (.clock(clock), .rst(rst), .fire(fire), .syncIn(syncIn));

    // Clock of 25 ns period
    initial begin
        forever #12.5 clock = ~clock;
    end

    // Trigger pulse counting and hang guard
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (triggerOut === 1'b1) trigHigh <= trigHigh + 1;
        if (cycles == 6000) begin
            errors++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        if (errors == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask

    // Bus write: address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
        req.awaddr <= a;
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        do begin
            @(posedge clock);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
        end while (!rsp.bvalid);
        chk("bresp", 32'(er), 32'(rsp.bresp));
        req.bready <= 1'b0;
        @(posedge clock);
    endtask

    // Bus read with expected data and response
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        do begin
            @(posedge clock);
            if (rsp.arready) req.arvalid <= 1'b0;
        end while (!rsp.rvalid);
        chk("rdata", e, rsp.rdata);
        chk("rresp", 32'(er), 32'(rsp.rresp));
        req.rready <= 1'b0;
        @(posedge clock);
    endtask

    // One rising edge from the chosen peer timers
    task automatic pulse(input logic [3:0] m);
        fire <= m;
        @(posedge clock);
        fire <= 4'h0;
        tick(6);
    endtask

    // Main sequence
    initial begin
        tick(12);
        rst <= 1'b0;
        tick(1);
        chk("arready", 1, rsp.arready);
        chk("trigger", 0, triggerOut);
        rd(OFF_RELOAD, 32'h0000ffff);
        wr(8'h40, 32'h1, RESP_SLVERR);
        rd(8'h40, 32'h0, RESP_SLVERR);
        t0 = trigHigh;
        wr(OFF_EGR, 32'h1);
        tick(4);
        rd(OFF_EGR, 32'h0);
        chk("resetPulse", 1, 32'(trigHigh - t0));
        wr(OFF_CTRL1, 32'h2);
        wr(OFF_CHCFG, 32'h9);
        rd(OFF_CHACT, 32'h0);
        wr(OFF_EGR, 32'h2);
        tick(3);
        rd(OFF_CHACT, 32'h9);
        chk("chOut", 4'h1, chOut);
        rd(OFF_STAT, 32'h2);
        wr(OFF_CTRL2, 32'h10);
        wr(OFF_SMCR, 32'h20);
        wr(OFF_CHCFG, 32'h10);
        pulse(4'h1);
        rd(OFF_CHACT, 32'h9);
        pulse(4'h4);
        rd(OFF_CHACT, 32'h10);
        chk("chOutN", 4'h1, chOutN);
        wr(OFF_SMCR, 32'h1);
        wr(OFF_CNT, 32'h55);
        pulse(4'h1);
        rd(OFF_CNT, 32'h0);
        wr(OFF_SMCR, 32'h2);
        wr(OFF_CNT, 32'h5);
        wr(OFF_CTRL1, 32'h3);
        pulse(4'h1);
        pulse(4'h1);
        rd(OFF_CNT, 32'h7);
        wr(OFF_CTRL1, 32'h2);
        wr(OFF_CTRL2, 32'h2);
        wr(OFF_SMCR, 32'h3);
        wr(OFF_CNT, 32'h5);
        t0 = trigHigh;
        pulse(4'h1);
        rd(OFF_CNT, 32'h0);
        chk("updatePulse", 1, 32'(trigHigh - t0));
        wr(OFF_SMCR, 32'h0);
        wr(OFF_RELOAD, 32'h9);
        wr(OFF_EGR, 32'h1);
        wr(OFF_CMP1, 32'h2);
        wr(OFF_CTRL2, 32'h3);
        wr(OFF_CNT, 32'h0);
        t0 = trigHigh;
        wr(OFF_CTRL1, 32'h1);
        tick(40);
        wr(OFF_CTRL1, 32'h0);
        chk("cmpPulses", 1, 32'((trigHigh - t0) inside {[3:6]}));
        wr(OFF_CTRL2, 32'h1);
        for (int c = 1; c >= 0; c--) begin
            wr(OFF_CTRL1, 32'(c));
            tick(4);
            chk("enableTrig", 32'(c), triggerOut);
        end
        for (int i = 0; i < 4; i++) begin
            wr(OFF_CHCFG, 32'h1 << (5 * i));
            wr(OFF_CTRL2, 32'(4 + i));
            tick(4);
            chk("refTrig", 1, triggerOut);
            wr(OFF_CTRL2, 32'(4 + (i + 1) % 4));
            tick(4);
            chk("otherRef", 0, triggerOut);
        end
        give_verdict();
    end
endmodule
